// ---- design/cfdr_defines.vh ----
// Purpose: Offsets, field positions, reset values and the fraction limit for the clock status and fine delay registers
// Assumes: APB byte addresses; each register is one aligned 32-bit word
// Notes:   Register index times four gives the byte address
`ifndef CFDR_DEFINES_VH
`define CFDR_DEFINES_VH

// Register indices, as printed
`define CFDR_IDX_STATUS        10'h01F
`define CFDR_IDX_BYPASS        10'h0A0
`define CFDR_IDX_RAMP_CAP      10'h0A1
`define CFDR_IDX_FRACTION      10'h0A2
`define CFDR_IDX_THRESH_SEL    10'h01A

// Status fields
`define CFDR_ST_LOCK           0
`define CFDR_ST_FIRST_REFERENCE_INPUT_ABOVE     1
`define CFDR_ST_SECOND_REFERENCE_INPUT_ABOVE     2
`define CFDR_ST_VCO_ABOVE      3

// Control fields
`define CFDR_BYPASS_BIT        0
`define CFDR_CAP_LSB           3
`define CFDR_CAP_MSB           5
`define CFDR_CUR_LSB           0
`define CFDR_CUR_MSB           2
`define CFDR_THRESH_BIT        6

// Reset values and the fraction limit
`define CFDR_BYPASS_RST        1'h1
`define CFDR_CAP_RST           3'h0
`define CFDR_CUR_RST           3'h0
`define CFDR_FRACTION_RST      6'h00
`define CFDR_THRESH_RST        1'h0
`define CFDR_FRACTION_MAX      6'h2F

`endif

// ---- design/cfdr_sync2.v ----
// Purpose: Two flip-flop synchroniser for a bus of pin levels
// Assumes: Inputs are quasi-static levels
// Notes:   First stage read only by the second stage
`timescale 1ns/100ps
module cfdr_sync2 #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input  wire             sys_clk_i,
  input  wire             rst_i,
  // Data
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_reg;

  // Two stages to settle metastability
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_o   <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule // cfdr_sync2

// ---- design/cfdr_regs.v ----
// Purpose: APB register slice: PLL/reference status and first fine-delay channel controls
// Assumes: 100 MHz sys_clk_i; status inputs come from analog monitors in other domains
// Notes:   Zero-wait-state APB slave, unmapped addresses read zero and raise pslverr
//
// Functional notes
// - Status bit 2 shows second reference above the threshold chosen by select bit
// - Status bit 1 shows first reference above the selected threshold; read-only
// - Status bit 0 shows digital lock detect, 1 while locked; read-only
// - VCO comparison bit reads 1 above threshold frequency, 0 below
// - Bit 0 of 0x0A0 selects bypass or use of the fine delay
// - Field [5:3] of 0x0A1 selects ramp capacitor count, 000 gives 4
// - Full-scale delay set by capacitor count together with ramp current
// - VCO comparison flag sits at bit 3 of the status register
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`include "cfdr_defines.vh"
module cfdr_regs #(
  parameter AW = 12
) (
  // Clock and reset
  input  wire          sys_clk_i,
  input  wire          rst_i,
  // APB slave
  input  wire          psel_i,
  input  wire          penable_i,
  input  wire          pwrite_i,
  input  wire [AW-1:0] paddr_i,
  input  wire [31:0]   pwdata_i,
  output reg  [31:0]   prdata_o,
  output reg           pready_o,
  output reg           pslverr_o,
  // Monitor levels from the analog side
  input  wire          pll_locked_i,
  input  wire          first_reference_input_above_i,
  input  wire          second_reference_input_above_i,
  input  wire          vco_above_i,
  // Threshold select to the reference monitors
  output reg           ref_thresh_sel_o,
  // Fine delay controls for the first fine-delay output
  output reg           first_fine_delay_output_bypass_o,
  output reg  [2:0]    first_fine_delay_output_ramp_caps_o,
  output reg  [2:0]    first_fine_delay_output_ramp_current_o,
  output reg  [5:0]    first_fine_delay_output_fraction_o,
  output reg  [7:0]    first_fine_delay_output_full_scale_o
);

  // Byte address of a register index
  function [AW-1:0] cfdr_addr;
    input [9:0] idx;
    begin
      cfdr_addr = {idx, 2'b00};
    end
  endfunction

  // Ramp capacitor count for the 3-bit select; 111 treated as 2
  function [2:0] cfdr_cap_count;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    cfdr_cap_count = 3'h4;
        3'h1:    cfdr_cap_count = 3'h3;
        3'h2:    cfdr_cap_count = 3'h3;
        3'h3:    cfdr_cap_count = 3'h2;
        3'h4:    cfdr_cap_count = 3'h3;
        3'h5:    cfdr_cap_count = 3'h2;
        3'h6:    cfdr_cap_count = 3'h2;
        default: cfdr_cap_count = 3'h2;
      endcase
    end
  endfunction

  wire [3:0] status_sync;
  reg        bypass_reg;
  reg  [2:0] cap_reg;
  reg  [2:0] cur_reg;
  reg  [5:0] frac_reg;
  reg        thresh_reg;
  reg  [31:0] rdata_next;
  reg         hit_next;
  reg  [7:0]  full_scale_next;

  // Monitor levels are from foreign domains, so synchronise first
  cfdr_sync2 #(
    .WIDTH (4)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   ({vco_above_i, second_reference_input_above_i,
                 first_reference_input_above_i, pll_locked_i}),
    .sync_o    (status_sync)
  );

  wire setup_phase = psel_i & ~penable_i;
  wire wr_access   = psel_i & penable_i & pwrite_i & pready_o;

  // Read mux and address decode
  always @* begin
    rdata_next = 32'h0000_0000;
    hit_next   = 1'b1;
    if (paddr_i == cfdr_addr(`CFDR_IDX_STATUS)) begin
      rdata_next[`CFDR_ST_LOCK]       = status_sync[0];
      rdata_next[`CFDR_ST_FIRST_REFERENCE_INPUT_ABOVE] = status_sync[1];
      rdata_next[`CFDR_ST_SECOND_REFERENCE_INPUT_ABOVE] = status_sync[2];
      rdata_next[`CFDR_ST_VCO_ABOVE]  = status_sync[3];
    end else if (paddr_i == cfdr_addr(`CFDR_IDX_BYPASS)) begin
      rdata_next[`CFDR_BYPASS_BIT] = bypass_reg;
    end else if (paddr_i == cfdr_addr(`CFDR_IDX_RAMP_CAP)) begin
      rdata_next[`CFDR_CAP_MSB:`CFDR_CAP_LSB] = cap_reg;
      rdata_next[`CFDR_CUR_MSB:`CFDR_CUR_LSB] = cur_reg;
    end else if (paddr_i == cfdr_addr(`CFDR_IDX_FRACTION)) begin
      rdata_next[5:0] = frac_reg;
    end else if (paddr_i == cfdr_addr(`CFDR_IDX_THRESH_SEL)) begin
      rdata_next[`CFDR_THRESH_BIT] = thresh_reg;
    end else begin
      hit_next = 1'b0;
    end
  end

  // APB answer: ready in the access cycle, data latched at setup
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= setup_phase;
      pslverr_o <= setup_phase & ~hit_next;
      if (setup_phase & ~pwrite_i) begin
        prdata_o <= rdata_next;
      end else if (~psel_i) begin
        prdata_o <= 32'h0000_0000;
      end
    end
  end

  // Control registers; status word ignores writes
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bypass_reg <= `CFDR_BYPASS_RST;
      cap_reg    <= `CFDR_CAP_RST;
      cur_reg    <= `CFDR_CUR_RST;
      frac_reg   <= `CFDR_FRACTION_RST;
      thresh_reg <= `CFDR_THRESH_RST;
    end else if (wr_access) begin
      if (paddr_i == cfdr_addr(`CFDR_IDX_BYPASS)) begin
        bypass_reg <= pwdata_i[`CFDR_BYPASS_BIT];
      end
      if (paddr_i == cfdr_addr(`CFDR_IDX_RAMP_CAP)) begin
        cap_reg <= pwdata_i[`CFDR_CAP_MSB:`CFDR_CAP_LSB];
        cur_reg <= pwdata_i[`CFDR_CUR_MSB:`CFDR_CUR_LSB];
      end
      if (paddr_i == cfdr_addr(`CFDR_IDX_FRACTION)) begin
        // Stored as written; software keeps it in range
        frac_reg <= pwdata_i[5:0];
      end
      if (paddr_i == cfdr_addr(`CFDR_IDX_THRESH_SEL)) begin
        thresh_reg <= pwdata_i[`CFDR_THRESH_BIT];
      end
    end
  end

  // Full-scale code: capacitor count times current step (1..8 of 200 uA)
  always @* begin
    full_scale_next = {5'h00, cfdr_cap_count(cap_reg)} * ({5'h00, cur_reg} + 8'h01);
  end

  // Outputs to the analog delay path, all registered
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_thresh_sel_o                       <= `CFDR_THRESH_RST;
      first_fine_delay_output_bypass_o       <= `CFDR_BYPASS_RST;
      first_fine_delay_output_ramp_caps_o    <= 3'h4;
      first_fine_delay_output_ramp_current_o <= `CFDR_CUR_RST;
      first_fine_delay_output_fraction_o     <= `CFDR_FRACTION_RST;
      first_fine_delay_output_full_scale_o   <= 8'h04;
    end else begin
      ref_thresh_sel_o                       <= thresh_reg;
      // High bypasses the delay, low routes through it
      first_fine_delay_output_bypass_o       <= bypass_reg;
      first_fine_delay_output_ramp_caps_o    <= cfdr_cap_count(cap_reg);
      first_fine_delay_output_ramp_current_o <= cur_reg;
      // Bypass forces zero fraction so no residual delay leaks through
      first_fine_delay_output_fraction_o     <= bypass_reg ? 6'h00 : frac_reg;
      first_fine_delay_output_full_scale_o   <= full_scale_next;
    end
  end

endmodule // cfdr_regs

// ---- testbench/cfdr_regs_checker.sv ----
// Purpose: Assertions for the status and fine delay register slice
// Assumes: Zero-wait APB, byte address is index times four
// Notes:   Shadows copy completed writes
`timescale 1ns/100ps
module cfdr_regs_checker #(parameter AW = 12) (
  input wire          sys_clk_i, rst_i, psel_i, penable_i, pwrite_i,
  input wire [AW-1:0] paddr_i,
  input wire [31:0]   pwdata_i, prdata_o,
  input wire          pready_o, pslverr_o, pll_locked_i, vco_above_i,
  input wire          first_reference_input_above_i, second_reference_input_above_i,
  input wire          first_fine_delay_output_bypass_o,
  input wire [2:0]    first_fine_delay_output_ramp_caps_o,
  input wire [5:0]    first_fine_delay_output_fraction_o,
  input wire [7:0]    first_fine_delay_output_full_scale_o
);
  reg       byp_q;
  reg [5:0] rmp_q, frc_q;
  wire      acc = psel_i && penable_i && pwrite_i && pready_o;
  wire [3:0] st = {vco_above_i, second_reference_input_above_i,
                   first_reference_input_above_i, pll_locked_i};
  wire [2:0] cap = rmp_q[5:3];
  wire [2:0] ncap = (cap == 3'h0) ? 3'h4 : (cap == 3'h3 || cap > 3'h4) ? 3'h2 : 3'h3;
  // Shadows move only on a write access, as the slave does
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      byp_q <= 1'h1;
      rmp_q <= 6'h00;
      frc_q <= 6'h00;
    end else if (acc) begin
      if (paddr_i == 12'h280) byp_q <= pwdata_i[0];
      if (paddr_i == 12'h284) rmp_q <= pwdata_i[5:0];
      if (paddr_i == 12'h288) frc_q <= pwdata_i[5:0];
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence setup_s; psel_i && !penable_i; endsequence
  sequence wr_done_s; acc ##1 1'b1; endsequence
  // Inputs steady long enough to pass the synchroniser
  sequence st_rd_s;
    psel_i && penable_i && !pwrite_i && paddr_i == 12'h07C &&
    st == $past(st, 1) && st == $past(st, 2) && st == $past(st, 3);
  endsequence
  ready_pulse_a: assert property (setup_s |=> pready_o ##1 !pready_o)
    else $error("pready not one access cycle");
  slverr_map_a: assert property (setup_s |=> pslverr_o == !(paddr_i == 12'h07C ||
    paddr_i == 12'h068 || paddr_i == 12'h280 || paddr_i == 12'h284 || paddr_i == 12'h288))
    else $error("pslverr wrong");
  lock_stat_a: assert property (st_rd_s |-> prdata_o[0] == st[0])
    else $error("lock bit wrong");
  ref_stat_a: assert property (st_rd_s |-> prdata_o[2:1] == st[2:1])
    else $error("reference bits wrong");
  vco_stat_a: assert property (st_rd_s |-> prdata_o[31:3] == {28'h0, st[3]})
    else $error("vco bit wrong");
  bypass_out_a: assert property (wr_done_s |=> first_fine_delay_output_bypass_o == byp_q)
    else $error("bypass output wrong");
  caps_out_a: assert property (wr_done_s |=> first_fine_delay_output_ramp_caps_o == ncap)
    else $error("capacitor count wrong");
  scale_out_a: assert property (wr_done_s |=> first_fine_delay_output_full_scale_o ==
    {5'h0, ncap} * ({5'h0, rmp_q[2:0]} + 8'h01)) else $error("full scale wrong");
  frac_out_a: assert property (wr_done_s |=>
    first_fine_delay_output_fraction_o == (byp_q ? 6'h00 : frc_q)) else $error("fraction wrong");
endmodule // cfdr_regs_checker
bind cfdr_regs cfdr_regs_checker #(.AW(AW)) u_chk (.*);

// ---- testbench/cfdr_regs_test.sv ----
// Purpose: Self-checking bench for the status and fine delay registers
// Assumes: Zero-wait APB slave, byte address is index times four
// Notes:   APB answer taken at rising edges; outputs sampled on falling edges after writes, at rising edges after reads
`timescale 1ns/100ps
module cfdr_regs_test;
  reg sys_clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, er;
  reg [11:0] paddr_i = 0;
  reg [31:0] pwdata_i = 0, rd;
  reg pll_locked_i = 0, first_reference_input_above_i = 0;
  reg second_reference_input_above_i = 0, vco_above_i = 0;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, ref_thresh_sel_o, first_fine_delay_output_bypass_o;
  wire [2:0] first_fine_delay_output_ramp_caps_o, first_fine_delay_output_ramp_current_o;
  wire [5:0] first_fine_delay_output_fraction_o;
  wire [7:0] first_fine_delay_output_full_scale_o;
  integer num_errors = 0, checked = 0, i;
  // Capacitor count per select code, code 7 in the top slot
  localparam [23:0] CAPS = 24'h4934DC;
  cfdr_regs #(.AW(12)) DUT (.*);
  initial forever #5 sys_clk_i = ~sys_clk_i;
  task report_and_stop;
    begin
      if (num_errors == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // One APB transfer, held until pready is seen at a rising edge
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge sys_clk_i);
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'h2, w, a, d};
      @(posedge sys_clk_i) penable_i <= 1'b1;
      @(posedge sys_clk_i);
      while (pready_o !== 1'b1) @(posedge sys_clk_i);
      rd = prdata_o;
      er = pslverr_o;
      {psel_i, penable_i} <= 2'h0;
    end
  endtask
  task t_reset;
    begin
      apb(1'b0, 12'h280, 0); chk("bypass rd", rd, 1);
      chk("caps", first_fine_delay_output_ramp_caps_o, 4);
      chk("scale", first_fine_delay_output_full_scale_o, 4);
      chk("current", first_fine_delay_output_ramp_current_o, 0);
    end
  endtask
  // Status writes are ignored, reads follow the monitors
  task t_status;
    for (i = 0; i < 16; i = i + 1) begin
      @(posedge sys_clk_i) {vco_above_i, second_reference_input_above_i,
        first_reference_input_above_i, pll_locked_i} <= i[3:0];
      repeat (6) @(posedge sys_clk_i);
      apb(1'b1, 12'h07C, 32'hFFFFFFFF);
      apb(1'b0, 12'h07C, 0); chk("status", rd, i);
    end
  endtask
  task t_caps;
    for (i = 0; i < 8; i = i + 1) begin
      apb(1'b1, 12'h284, {26'h0, i[2:0], ~i[2:0]});
      repeat (2) @(negedge sys_clk_i);
      chk("caps", first_fine_delay_output_ramp_caps_o, CAPS[3*i +: 3]);
      chk("scale", first_fine_delay_output_full_scale_o, CAPS[3*i +: 3] * (8 - i));
      chk("current", first_fine_delay_output_ramp_current_o, 7 - i);
    end
  endtask
  task t_delay;
    begin
      apb(1'b1, 12'h288, 32'h2F);
      apb(1'b0, 12'h288, 0); chk("frac rd", rd, 32'h2F);
      chk("frac bypassed", first_fine_delay_output_fraction_o, 0);
      apb(1'b1, 12'h280, 0); repeat (2) @(negedge sys_clk_i);
      chk("frac", first_fine_delay_output_fraction_o, 32'h2F);
      chk("bypass", first_fine_delay_output_bypass_o, 0);
      apb(1'b1, 12'h068, 32'h40); repeat (2) @(negedge sys_clk_i);
      chk("thresh", ref_thresh_sel_o, 1);
      apb(1'b0, 12'h100, 0); chk("unmapped", {er, rd[30:0]}, 32'h80000000);
    end
  endtask
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset; t_status; t_caps; t_delay;
    report_and_stop;
  end
  // Whole run is a few hundred cycles
  initial begin #100000; num_errors = num_errors + 1; report_and_stop; end
endmodule // cfdr_regs_test
